// >>> verilog/mrx_pkg.sv
// Package: register map, field layout, timing and mode table of the lane receive setup block
package mrx_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_IF_POWER  = 10'h200; // Interface power, bit 0
  localparam logic [9:0] IDX_LANE_PD   = 10'h201; // Per-lane power down
  localparam logic [9:0] IDX_CAL_A     = 10'h2a7; // Termination cal, lanes 0,1,6,7
  localparam logic [9:0] IDX_CAL_B     = 10'h2ae; // Termination cal, lanes 2..5
  localparam logic [9:0] IDX_LINK_CFG  = 10'h210; // Link arrangement and modes
  localparam logic [9:0] IDX_LANE_RATE = 10'h211; // Lane rate in Mbps
  localparam logic [9:0] IDX_STATUS    = 10'h212; // Block status, read only

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_IF_POWER  = 8'h01;   // Interface starts powered down
  localparam logic [7:0]  RST_LANE_PD   = 8'hff;   // All lanes start powered down
  localparam logic [7:0]  RST_CAL       = 8'h00;   // No calibration pending
  localparam logic [15:0] RST_LINK_CFG  = 16'h0000; // Single link, mode 0, disabled
  localparam logic [13:0] RST_LANE_RATE = 14'h0000; // Rate not yet given

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_IF_PD      = 0;  // Interface power-down bit
  localparam int BIT_CFG_DUAL   = 0;  // Dual-link arrangement
  localparam int BIT_CFG_EN     = 1;  // Links enabled
  localparam int LSB_CFG_MODE0  = 4;  // Link 0 mode field
  localparam int LSB_CFG_MODE1  = 8;  // Link 1 mode field
  localparam int BIT_ST_MODE0   = 0;  // Link 0 mode legal
  localparam int BIT_ST_MODE1   = 1;  // Link 1 mode legal
  localparam int BIT_ST_RATE    = 2;  // Lane rate in range
  localparam int BIT_ST_REQ0    = 3;  // Link 0 requesting sync
  localparam int BIT_ST_REQ1    = 4;  // Link 1 requesting sync
  localparam int BIT_ST_CALA    = 5;  // Cal group A busy
  localparam int BIT_ST_CALB    = 6;  // Cal group B busy
  localparam int LSB_ST_SYNC    = 8;  // Per-lane sync flags
  localparam int LSB_ST_FACTOR  = 16; // Link 0 frames per processing clock
  localparam logic [7:0] CAL_START = 8'h01; // Value that starts autotune
  localparam logic [7:0] CAL_GRP_A = 8'hc3; // Lanes 0,1,6,7
  localparam logic [7:0] CAL_GRP_B = 8'h3c; // Lanes 2..5

  // ----------------------------------------------------------------
  // Rates and times
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ       = 10;    // System clock rate
  localparam int          CAL_TIME_NS   = 20000; // Autotune duration
  localparam int          CAL_CYCLES    = CAL_TIME_NS * CLK_MHZ / 1000; // Rounded down
  localparam logic [13:0] RATE_MIN_MBPS = 14'd1420;  // Lowest lane rate
  localparam logic [13:0] RATE_MAX_MBPS = 14'd10640; // Highest lane rate
  localparam int          WORD_W        = 40;  // Deserialized word width
  localparam int          SYM_W         = 10;  // One coded byte
  localparam int          SYNC_WORDS    = 4;   // Comma words to claim lane sync
  localparam logic [9:0]  COMMA_NEG     = 10'h0fa; // Sync character, negative disparity
  localparam logic [9:0]  COMMA_POS     = 10'h305; // Sync character, positive disparity

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       legal; // Mode exists
    logic [3:0] m;     // Converters
    logic [3:0] l;     // Lanes
    logic [3:0] s;     // Samples per converter per frame
    logic [3:0] f;     // Octets per frame per lane
  } mrx_mode_s;

  // Mode lookup; dual rejects modes 0-3, leaving modes 4-7, 9, 10
  function automatic mrx_mode_s mode_params(input logic [3:0] mode, input logic dual);
    mrx_mode_s p;
    p = '0;
    unique case (mode)
      4'h0:    p = '{1'b1, 4'h4, 4'h8, 4'h1, 4'h1};
      4'h1:    p = '{1'b1, 4'h4, 4'h8, 4'h2, 4'h2};
      4'h2:    p = '{1'b1, 4'h4, 4'h4, 4'h1, 4'h2};
      4'h3:    p = '{1'b1, 4'h4, 4'h2, 4'h1, 4'h4};
      4'h4:    p = '{1'b1, 4'h2, 4'h4, 4'h1, 4'h1};
      4'h5:    p = '{1'b1, 4'h2, 4'h4, 4'h2, 4'h2};
      4'h6:    p = '{1'b1, 4'h2, 4'h2, 4'h1, 4'h2};
      4'h7:    p = '{1'b1, 4'h2, 4'h1, 4'h1, 4'h4};
      4'h9:    p = '{1'b1, 4'h1, 4'h2, 4'h1, 4'h1};
      4'ha:    p = '{1'b1, 4'h1, 4'h1, 4'h1, 4'h2};
      default: p = '0;
    endcase
    if (dual && mode < 4'h4) begin
      p = '0;
    end
    return p;
  endfunction : mode_params

endpackage : mrx_pkg

// >>> verilog/mrx_lane_channel.sv
// One deserialized lane: word register, comma search and lane sync flag
`timescale 1ns/100ps
module mrx_lane_channel #(
  parameter int WORD_W = 40
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              enable_i, // Lane powered
  input  wire logic              valid_i,  // Word present
  input  wire logic [WORD_W-1:0] word_i,   // Parallel word
  output logic      [WORD_W-1:0] word_o,   // Registered word, zero when off
  output logic                   synced_o  // Lane has code group sync
);

  // ----------------------------------------------------------------
  // Checks and state
  // ----------------------------------------------------------------
  initial begin
    if (WORD_W != mrx_pkg::WORD_W) begin
      $error("mrx_lane_channel: word width must be 40");
    end
  end

  localparam int NSYM = WORD_W / mrx_pkg::SYM_W; // Four symbols per word

  logic [WORD_W-1:0] next_word;   // Next word register
  logic              next_synced; // Next sync flag
  logic [2:0]        comma_cnt;   // Comma words seen
  logic [2:0]        next_comma_cnt;
  logic              has_comma;   // Word holds a sync character

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    has_comma = 1'b0;
    for (int i = 0; i < NSYM; i++) begin
      if (word_i[i*mrx_pkg::SYM_W +: mrx_pkg::SYM_W] == mrx_pkg::COMMA_NEG ||
          word_i[i*mrx_pkg::SYM_W +: mrx_pkg::SYM_W] == mrx_pkg::COMMA_POS) begin
        has_comma = 1'b1;
      end
    end
    next_word      = word_o;
    next_synced    = synced_o;
    next_comma_cnt = comma_cnt;
    if (!enable_i) begin // Off lane gives nothing
      next_word      = '0;
      next_synced    = 1'b0;
      next_comma_cnt = '0;
    end else if (valid_i) begin // 1:40 word taken per clock
      next_word = word_i;
      if (has_comma && !synced_o) begin
        next_comma_cnt = comma_cnt + 3'd1;
        if (comma_cnt == 3'(mrx_pkg::SYNC_WORDS - 1)) begin
          next_synced = 1'b1;
        end
      end else if (!has_comma && !synced_o) begin
        next_comma_cnt = '0;
      end
    end else begin // Lost words drop sync
      next_synced    = 1'b0;
      next_comma_cnt = '0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_o    <= '0;
      synced_o  <= 1'b0;
      comma_cnt <= '0;
    end else begin
      word_o    <= next_word;
      synced_o  <= next_synced;
      comma_cnt <= next_comma_cnt;
    end
  end

endmodule : mrx_lane_channel

// >>> verilog/mrx_link_setup.sv
// Top: eight-lane serial receive front end with link setup registers on Wishbone
//
// Function
// - Eight lanes form one or two links
// - Single link accepts the ten listed modes
// - Dual link accepts modes 4-7, 9, 10
// - Processing clock lane/40; frame clock 4*pclk/F
// - Lane rate outside 1.42 to 10.64 Gbps holds the links down
// - Sync out 0 for single; 0/1 per link
// - Eight channels deliver 40-bit parallel words
// - Lane power-down bit x controls lane x
// - Writing 0x01 starts termination autotune per group
// - Byte rate lane/10; four-byte decoder per pclk
`timescale 1ns/100ps
module mrx_link_setup #(
  parameter int NUM_LANES  = 8,                      // Receive lanes
  parameter int CAL_CYCLES = mrx_pkg::CAL_CYCLES     // Autotune duration in clocks
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Wishbone classic slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [11:0]            wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // Deserialized lanes
  input  wire logic [NUM_LANES-1:0]   lane_valid_i,
  input  wire logic [NUM_LANES*40-1:0] lane_word_i,
  output logic      [NUM_LANES*40-1:0] lane_word_o,
  // Sync requests, low asks the transmitter to resync
  output logic                        sync_request_out_0_n_o,
  output logic                        sync_request_out_1_n_o,
  // Analog controls
  output logic      [NUM_LANES-1:0]   lane_power_down_o,
  output logic      [1:0]             term_cal_busy_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (NUM_LANES != 8) begin
      $error("mrx_link_setup: lane count must be 8");
    end
    if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin
      $error("mrx_link_setup: calibration count out of range");
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  if_power;             // Interface power register
  logic [7:0]  lane_power_down;      // Per-lane power-down register
  logic [7:0]  cal_a;                // Termination cal, group A
  logic [7:0]  cal_b;                // Termination cal, group B
  logic [15:0] link_cfg;             // Link arrangement and modes
  logic [13:0] lane_rate;            // Lane rate in Mbps
  logic [7:0]  next_if_power;
  logic [7:0]  next_lane_power_down;
  logic [7:0]  next_cal_a;
  logic [7:0]  next_cal_b;
  logic [15:0] next_link_cfg;
  logic [13:0] next_lane_rate;
  logic [31:0] next_dat;             // Next read data
  logic        next_ack;             // Next acknowledge
  logic        wr_req;               // Write lands on the ack edge
  logic [9:0]  idx;                  // Register index
  logic [31:0] status;               // Status word

  assign idx    = wb_adr_i[11:2];
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // Byte-lane merge for a narrow register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : merge16

  // Lanes of a link starting at a base lane
  function automatic logic [7:0] lane_span(input logic [3:0] l, input logic [2:0] base);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      if (i >= int'(base) && i < int'(base) + int'(l)) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : lane_span

  // Frames per processing clock, 4/F
  function automatic logic [3:0] pclk_factor(input logic [3:0] f);
    logic [3:0] r;
    r = '0;
    if (f != 4'h0) begin
      r = 4'(4'h4 / f);
    end
    return r;
  endfunction : pclk_factor

  // ----------------------------------------------------------------
  // Wishbone register access
  // ----------------------------------------------------------------
  always_comb begin
    next_if_power        = if_power;
    next_lane_power_down = lane_power_down;
    next_cal_a           = cal_a;
    next_cal_b           = cal_b;
    next_link_cfg        = link_cfg;
    next_lane_rate       = lane_rate;
    next_ack             = wb_cyc_i && wb_stb_i && !wb_ack_o; // One wait state
    next_dat             = wb_dat_o;
    if (wr_req && wb_sel_i[0]) begin
      unique case (idx)
        mrx_pkg::IDX_IF_POWER:  next_if_power        = wb_dat_i[7:0];
        mrx_pkg::IDX_LANE_PD:   next_lane_power_down = wb_dat_i[7:0];
        mrx_pkg::IDX_CAL_A:     next_cal_a           = wb_dat_i[7:0];
        mrx_pkg::IDX_CAL_B:     next_cal_b           = wb_dat_i[7:0];
        default: ;
      endcase
    end
    if (wr_req && idx == mrx_pkg::IDX_LINK_CFG) begin
      next_link_cfg = merge16(link_cfg, wb_dat_i, wb_sel_i);
    end
    if (wr_req && idx == mrx_pkg::IDX_LANE_RATE) begin
      next_lane_rate = 14'(merge16({2'b00, lane_rate}, wb_dat_i, wb_sel_i));
    end
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
      unique case (idx)
        mrx_pkg::IDX_IF_POWER:  next_dat = {24'h000000, if_power};
        mrx_pkg::IDX_LANE_PD:   next_dat = {24'h000000, lane_power_down};
        mrx_pkg::IDX_CAL_A:     next_dat = {24'h000000, cal_a};
        mrx_pkg::IDX_CAL_B:     next_dat = {24'h000000, cal_b};
        mrx_pkg::IDX_LINK_CFG:  next_dat = {16'h0000, link_cfg};
        mrx_pkg::IDX_LANE_RATE: next_dat = {18'h00000, lane_rate};
        mrx_pkg::IDX_STATUS:    next_dat = status;
        default:                next_dat = 32'h00000000; // Unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if_power        <= mrx_pkg::RST_IF_POWER;
      lane_power_down <= mrx_pkg::RST_LANE_PD;
      cal_a           <= mrx_pkg::RST_CAL;
      cal_b           <= mrx_pkg::RST_CAL;
      link_cfg        <= mrx_pkg::RST_LINK_CFG;
      lane_rate       <= mrx_pkg::RST_LANE_RATE;
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= 32'h00000000;
    end else begin
      if_power        <= next_if_power;
      lane_power_down <= next_lane_power_down;
      cal_a           <= next_cal_a;
      cal_b           <= next_cal_b;
      link_cfg        <= next_link_cfg;
      lane_rate       <= next_lane_rate;
      wb_ack_o        <= next_ack;
      wb_dat_o        <= next_dat;
    end
  end

  // ----------------------------------------------------------------
  // Link arrangement and mode checks
  // ----------------------------------------------------------------
  logic              dual;        // Two links
  mrx_pkg::mrx_mode_s mode0;      // Link 0 parameters
  mrx_pkg::mrx_mode_s mode1;      // Link 1 parameters
  logic              rate_ok;     // Lane rate within limits
  logic [7:0]        lane_on;     // Lanes powered
  logic [7:0]        lanes0;      // Lanes of link 0
  logic [7:0]        lanes1;      // Lanes of link 1
  logic [7:0]        lane_synced; // Lane sync flags

  assign dual    = link_cfg[mrx_pkg::BIT_CFG_DUAL];
  assign mode0   = mrx_pkg::mode_params(link_cfg[mrx_pkg::LSB_CFG_MODE0 +: 4], dual);
  assign mode1   = mrx_pkg::mode_params(link_cfg[mrx_pkg::LSB_CFG_MODE1 +: 4], 1'b1);
  assign rate_ok = lane_rate >= mrx_pkg::RATE_MIN_MBPS &&
                   lane_rate <= mrx_pkg::RATE_MAX_MBPS;
  assign lane_on = ~lane_power_down & {8{~if_power[mrx_pkg::BIT_IF_PD]}};
  assign lanes0  = lane_span(mode0.l, 3'd0);
  assign lanes1  = dual ? lane_span(mode1.l, 3'd4) : 8'h00; // Link 1 from lane 4

  // ----------------------------------------------------------------
  // Lane channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
    mrx_lane_channel #(
      .WORD_W (mrx_pkg::WORD_W)
    ) u_chan (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .enable_i (lane_on[g]),
      .valid_i  (lane_valid_i[g]),
      .word_i   (lane_word_i[g*40 +: 40]),     // Four coded bytes per pclk
      .word_o   (lane_word_o[g*40 +: 40]),
      .synced_o (lane_synced[g])
    );
  end

  // ----------------------------------------------------------------
  // Sync request outputs
  // ----------------------------------------------------------------
  logic link0_up;    // Link 0 may run
  logic link1_up;    // Link 1 may run
  logic next_req0_n;
  logic next_req1_n;

  assign link0_up = link_cfg[mrx_pkg::BIT_CFG_EN] && mode0.legal && rate_ok &&
                    ((lanes0 & lane_on) == lanes0);
  assign link1_up = link_cfg[mrx_pkg::BIT_CFG_EN] && dual && mode1.legal && rate_ok &&
                    ((lanes1 & lane_on) == lanes1);

  // Request resync (low) until every lane of the link holds sync
  always_comb begin
    next_req0_n = link0_up && ((lane_synced & lanes0) == lanes0);
    next_req1_n = 1'b1;
    if (!link1_up || (lane_synced & lanes1) != lanes1) begin
      next_req1_n = 1'b0; // Link 1 own request
    end
    if (!dual) begin
      next_req1_n = 1'b1; // Single link uses output 0 only
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_request_out_0_n_o <= 1'b1;
      sync_request_out_1_n_o <= 1'b1;
    end else begin
      sync_request_out_0_n_o <= next_req0_n;
      sync_request_out_1_n_o <= next_req1_n;
    end
  end

  // ----------------------------------------------------------------
  // Termination autotune and lane power outputs
  // ----------------------------------------------------------------
  logic [15:0] cal_cnt_a;      // Group A remaining cycles
  logic [15:0] cal_cnt_b;      // Group B remaining cycles
  logic [15:0] next_cal_cnt_a;
  logic [15:0] next_cal_cnt_b;
  logic [7:0]  next_lane_pd_o;

  always_comb begin
    next_cal_cnt_a = (cal_cnt_a != 16'h0000) ? cal_cnt_a - 16'h0001 : 16'h0000;
    next_cal_cnt_b = (cal_cnt_b != 16'h0000) ? cal_cnt_b - 16'h0001 : 16'h0000;
    if (wr_req && wb_sel_i[0] && idx == mrx_pkg::IDX_CAL_A &&
        wb_dat_i[7:0] == mrx_pkg::CAL_START) begin
      next_cal_cnt_a = 16'(CAL_CYCLES); // Start group A
    end
    if (wr_req && wb_sel_i[0] && idx == mrx_pkg::IDX_CAL_B &&
        wb_dat_i[7:0] == mrx_pkg::CAL_START) begin
      next_cal_cnt_b = 16'(CAL_CYCLES); // Start group B
    end
    next_lane_pd_o = ~lane_on;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_cnt_a         <= 16'h0000;
      cal_cnt_b         <= 16'h0000;
      lane_power_down_o <= mrx_pkg::RST_LANE_PD;
      term_cal_busy_o   <= 2'b00;
    end else begin
      cal_cnt_a         <= next_cal_cnt_a;
      cal_cnt_b         <= next_cal_cnt_b;
      lane_power_down_o <= next_lane_pd_o;
      term_cal_busy_o   <= {next_cal_cnt_b != 16'h0000, next_cal_cnt_a != 16'h0000};
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  always_comb begin
    status = 32'h00000000;
    status[mrx_pkg::BIT_ST_MODE0] = mode0.legal;
    status[mrx_pkg::BIT_ST_MODE1] = dual && mode1.legal;
    status[mrx_pkg::BIT_ST_RATE]  = rate_ok;
    status[mrx_pkg::BIT_ST_REQ0]  = !sync_request_out_0_n_o;
    status[mrx_pkg::BIT_ST_REQ1]  = !sync_request_out_1_n_o;
    status[mrx_pkg::BIT_ST_CALA]  = term_cal_busy_o[0];
    status[mrx_pkg::BIT_ST_CALB]  = term_cal_busy_o[1];
    status[mrx_pkg::LSB_ST_SYNC +: 8]   = lane_synced & lane_on;
    status[mrx_pkg::LSB_ST_FACTOR +: 4] = pclk_factor(mode0.f); // Frame = 4*pclk/F
  end

endmodule : mrx_link_setup

// >>> testbench/mrx_link_setup_chk.sv
// Checker: bus, sync and calibration timing at the link setup ports
`timescale 1ns/100ps
module mrx_link_setup_chk #(
  parameter int NUM_LANES  = 8,
  parameter int CAL_CYCLES = 5
) (
  input logic                    clk_i,
  input logic                    rst_i,
  input logic                    wb_cyc_i,
  input logic                    wb_stb_i,
  input logic                    wb_we_i,
  input logic [11:0]             wb_adr_i,
  input logic [3:0]              wb_sel_i,
  input logic [31:0]             wb_dat_i,
  input logic                    wb_ack_o,
  input logic [NUM_LANES*40-1:0] lane_word_o,
  input logic                    sync_request_out_0_n_o,
  input logic [NUM_LANES-1:0]    lane_power_down_o,
  input logic [1:0]              term_cal_busy_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [NUM_LANES-1:0] wz;   // Lane output word is zero
  logic [15:0]          c_a;  // Cycles cal A has been busy
  logic                 take; // Bus request taken this edge
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Zero test per lane
  always_comb begin
    for (int g = 0; g < NUM_LANES; g++) wz[g] = (lane_word_o[g*40+:40] == 40'h0);
  end
  // Busy length counter
  always_ff @(posedge clk_i) begin
    c_a <= (rst_i || !term_cal_busy_o[0]) ? 16'h0 : c_a + 16'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answers: assert property (take |=> wb_ack_o) else $error("no ack");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(take)) else $error("stray ack");
  a_sync_lane_off: assert property (lane_power_down_o[0] [*3] |-> !sync_request_out_0_n_o)
    else $error("link up with lane 0 off");
  a_sync_rise_on: assert property ($rose(sync_request_out_0_n_o) |-> !lane_power_down_o[0])
    else $error("link up on dead lane");
  a_off_word_zero: assert property ((lane_power_down_o & $past(lane_power_down_o) & ~wz) == '0)
    else $error("word from powered-off lane");
  a_cal_length: assert property ($fell(term_cal_busy_o[0]) |-> c_a == CAL_CYCLES)
    else $error("cal busy length");
  a_cal_a_start: assert property (take && wb_we_i && wb_sel_i[0] && wb_dat_i[7:0] == 8'h01
    && wb_adr_i[11:2] == mrx_pkg::IDX_CAL_A |-> ##2 term_cal_busy_o[0]) else $error("cal A idle");
  a_cal_b_start: assert property (take && wb_we_i && wb_sel_i[0] && wb_dat_i[7:0] == 8'h01
    && wb_adr_i[11:2] == mrx_pkg::IDX_CAL_B |-> ##2 term_cal_busy_o[1]) else $error("cal B idle");
endmodule : mrx_link_setup_chk
bind mrx_link_setup mrx_link_setup_chk #(.NUM_LANES(NUM_LANES), .CAL_CYCLES(CAL_CYCLES)) u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
  .lane_word_o, .sync_request_out_0_n_o, .lane_power_down_o, .term_cal_busy_o);

// >>> testbench/mrx_tx_model.sv
// Transmitter model: sync characters while its link asks, counted payload otherwise
`timescale 1ns/100ps
module mrx_tx_model (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         sync_0_n_i, // Link 0 request, low asks resync
  input  wire logic         sync_1_n_i, // Link 1 request
  input  wire logic         dual_i,     // Lanes 4..7 follow link 1
  input  wire logic         stop_i,     // Stall: lanes go quiet
  output logic      [7:0]   valid_o,
  output logic      [319:0] word_o
);
  logic [9:0] cnt; // Payload counter
  // Lane drivers
  always @(posedge clk_i) begin
    cnt <= rst_i ? 10'h000 : cnt + 10'h001;
    for (int g = 0; g < 8; g++) begin
      valid_o[g] <= !rst_i && !stop_i;
      if (rst_i || stop_i) begin
        word_o[g*40+:40] <= ~word_o[g*40+:40]; // Quiet lane shows no stale word
      end else if ((dual_i && g > 3) ? !sync_1_n_i : !sync_0_n_i) begin
        word_o[g*40+:40] <= {2{mrx_pkg::COMMA_POS, mrx_pkg::COMMA_NEG}};
      end else begin
        word_o[g*40+:40] <= {4{cnt ^ 10'(g)}}; // Payload
      end
    end
  end
endmodule : mrx_tx_model

// >>> testbench/test_mrx_link_setup.sv
// Bench: registers, link bring-up, mode table, rate limits and calibration
`timescale 1ns/100ps
module test_mrx_link_setup;
  logic         clk_i, rst_i, cyc, stb, we, dual, stop, ack;
  logic [11:0]  adr;
  logic [31:0]  dat, rd, dat_o;
  logic [7:0]   vld, pd, ppd, pv;
  logic [319:0] wi, wo, pw;
  logic [1:0]   busy;
  logic         s0_n, s1_n;
  logic [15:0]  lfsr;
  logic [13:0]  r;
  logic [3:0]   f;
  int           mismatches, n_checks;
  mrx_link_setup #(.CAL_CYCLES(5)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .lane_valid_i(vld), .lane_word_i(wi), .lane_word_o(wo),
    .sync_request_out_0_n_o(s0_n), .sync_request_out_1_n_o(s1_n),
    .lane_power_down_o(pd), .term_cal_busy_o(busy));
  mrx_tx_model u_tx (.clk_i(clk_i), .rst_i(rst_i), .sync_0_n_i(s0_n), .sync_1_n_i(s1_n),
    .dual_i(dual), .stop_i(stop), .valid_o(vld), .word_o(wi));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  // Octets per frame, zero if not offered
  function automatic logic [3:0] f_of(input int m, input bit d);
    case (m)
      0, 4, 9:        f_of = 4'h1;
      1, 2, 5, 6, 10: f_of = 4'h2;
      3, 7:           f_of = 4'h4;
      default:        f_of = 4'h0;
    endcase
    if (d && m < 4) f_of = 4'h0;
  endfunction : f_of
  task automatic test_done;
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // One classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [9:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, i, 2'b00, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
    if (n >= 50) begin
      mismatches++;
      test_done();
    end
  endtask : wb
  task automatic rc(input logic [9:0] i, input logic [31:0] e);
    wb(1'b0, i, 32'h0);
    chk(rd, e);
  endtask : rc
  // Status register read
  task automatic st;
    wb(1'b0, mrx_pkg::IDX_STATUS, 32'h0);
  endtask : st
  task automatic ws(input logic a, input logic b);
    int n;
    for (n = 0; n < 100 && {s0_n, s1_n} !== {a, b}; n++) @(posedge clk_i);
    chk({s0_n, s1_n}, {a, b});
    if ({s0_n, s1_n} !== {a, b}) test_done();
  endtask : ws
  // Lane words one edge later, zero when off
  always @(posedge clk_i) begin
    for (int g = 0; g < 8; g++)
      if (!rst_i && ppd[g] === pd[g] && (pv[g] || ppd[g]))
        chk(wo[g*40+:40], ppd[g] ? 40'h0 : pw[g*40+:40]);
    {pw, pv, ppd} = {wi, vld, pd};
  end
  initial begin
    {rst_i, cyc, stb, we, adr, dat, dual, stop, lfsr} = {4'h8, 12'h0, 32'h0, 2'b00, 16'd48};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(mrx_pkg::IDX_IF_POWER, 32'h01);
    rc(mrx_pkg::IDX_LANE_PD, 32'hff);
    rc(mrx_pkg::IDX_CAL_A, 32'h00);
    rc(10'h3ff, 32'h00);
    wb(1'b1, mrx_pkg::IDX_IF_POWER, 32'h0);
    wb(1'b1, mrx_pkg::IDX_LANE_PD, 32'h0);
    wb(1'b1, mrx_pkg::IDX_LANE_RATE, 32'd10000);
    wb(1'b1, mrx_pkg::IDX_LINK_CFG, 32'h2);
    ws(1'b1, 1'b1);
    st();
    chk(rd & 32'h000fff0d, 32'h0004ff05);
    stop <= 1'b1;
    ws(1'b0, 1'b1);
    stop <= 1'b0;
    ws(1'b1, 1'b1);
    for (int m = 0; m < 32; m++) begin
      f = f_of(m % 16, m / 16);
      wb(1'b1, mrx_pkg::IDX_LINK_CFG, (m < 16) ? m * 16 + 2 : (m % 16) * 272 + 3);
      st();
      chk(rd & {12'h0, {4{f != 0}}, 14'h0, m > 15, 1'b1},
          {12'h0, f ? 4'(4 / f) : 4'h0, 14'h0, (f != 0) && m > 15, f != 0});
    end
    dual <= 1'b1;
    wb(1'b1, mrx_pkg::IDX_LINK_CFG, 32'h663);
    wb(1'b1, mrx_pkg::IDX_LANE_PD, 32'hcc);
    ws(1'b1, 1'b1);
    wb(1'b1, mrx_pkg::IDX_LANE_PD, 32'hdc);
    ws(1'b1, 1'b0);
    for (int i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      r = (i < 4) ? 14'(i < 2 ? 1419 + i : 10638 + i) : 14'(lfsr % 16'd12000);
      wb(1'b1, mrx_pkg::IDX_LANE_RATE, {18'h0, r});
      st();
      chk(rd[2], r >= 14'd1420 && r <= 14'd10640);
    end
    wb(1'b1, mrx_pkg::IDX_CAL_A, 32'h01);
    wb(1'b1, mrx_pkg::IDX_CAL_B, 32'h01);
    #1 chk(busy, 2'b11);
    repeat (10) @(posedge clk_i);
    #1 chk(busy, 2'b00);
    rc(mrx_pkg::IDX_CAL_B, 32'h01);
    wb(1'b1, mrx_pkg::IDX_IF_POWER, 32'h1);
    ws(1'b0, 1'b0);
    test_done();
  end
endmodule : test_mrx_link_setup
